//--- rtl/mpu_access_permission_check.sv
// Region permission check and attribute decode for the protection unit
`timescale 1ns/10ps
`default_nettype none
module mpu_access_permission_check #(
  parameter int unsigned NREG = mpu_perm_pkg::NUM_REGIONS
) (
  // Clock and reset
  input  wire logic                                    ref_clk_i,
  input  wire logic                                    rstn_i,
  // Configuration
  input  wire logic                                    mpu_en_i,
  input  wire logic                                    bg_en_i,
  input  wire mpu_perm_pkg::region_attr_t [NREG-1:0]  region_attr_i,
  input  wire mpu_perm_pkg::mem_attr_t                bg_attr_i,
  // Access request with per-region address match
  input  wire mpu_perm_pkg::access_t                  access_i,
  input  wire logic [NREG-1:0]                         region_hit_i,
  // Status clear, write one to clear
  input  wire logic [mpu_perm_pkg::FSTAT_W-1:0]       fstat_clr_i,
  // Check result
  output logic                                         rsp_valid_o,
  output logic                                         fault_o,
  output logic                                         mm_fault_o,
  output mpu_perm_pkg::mem_attr_t                     attr_o,
  output logic [mpu_perm_pkg::FSTAT_W-1:0]            mem_fault_status_reg_o,
  output logic [mpu_perm_pkg::ADDR_W-1:0]             fault_addr_o
);

  typedef struct packed {
    logic                              rsp_valid;
    logic                              fault;
    logic                              mm_fault;
    mpu_perm_pkg::mem_attr_t           attr;
    logic [mpu_perm_pkg::FSTAT_W-1:0]  fstat;
    logic [mpu_perm_pkg::ADDR_W-1:0]   faddr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Permission table lookup, reserved code treated as no access
  function automatic logic perm_ok(input logic [2:0] perm, input logic priv,
                                   input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (perm)
      mpu_perm_pkg::PERM_NONE:    ok = 1'b0;              // RULE3
      mpu_perm_pkg::PERM_PRIV:    ok = priv;              // RULE4
      mpu_perm_pkg::PERM_URO:     ok = priv | ~wr;        // RULE5
      mpu_perm_pkg::PERM_FULL:    ok = 1'b1;              // RULE5
      mpu_perm_pkg::PERM_RSVD:    ok = 1'b0;              // RULE2
      mpu_perm_pkg::PERM_PRIV_RO: ok = priv & ~wr;        // RULE6
      mpu_perm_pkg::PERM_RO_A,
      mpu_perm_pkg::PERM_RO_B:    ok = ~wr;               // RULE7
    endcase
    return ok;
  endfunction : perm_ok

  // Memory type and policy decode; result is reported, never gates access
  function automatic mpu_perm_pkg::mem_attr_t decode(input mpu_perm_pkg::region_attr_t a);
    mpu_perm_pkg::mem_attr_t m;
    m.mtype        = mpu_perm_pkg::MT_RSVD;
    m.shareable    = 1'b0;
    m.inner_policy = mpu_perm_pkg::CP_NONCACHE;
    m.outer_policy = mpu_perm_pkg::CP_NONCACHE;
    if (a.type_extension_field[mpu_perm_pkg::TYPE_CACHED_BIT]) begin
      m.mtype        = mpu_perm_pkg::MT_NORMAL;                                 // RULE10
      m.shareable    = a.s;
      m.outer_policy = mpu_perm_pkg::cache_pol_t'(a.type_extension_field[1:0]); // RULE11
      m.inner_policy = mpu_perm_pkg::cache_pol_t'({a.c, a.b});                  // RULE11
    end else begin
      unique case (a.type_extension_field)
        mpu_perm_pkg::TYPE_BASIC: begin
          if (a.c) begin
            m.mtype        = mpu_perm_pkg::MT_NORMAL;                           // RULE8
            m.shareable    = a.s;
            m.inner_policy = a.b ? mpu_perm_pkg::CP_WB_NOWA : mpu_perm_pkg::CP_WT_NOWA;
            m.outer_policy = m.inner_policy;
          end else begin
            m.mtype     = a.b ? mpu_perm_pkg::MT_DEVICE : mpu_perm_pkg::MT_ORDERED; // RULE8
            m.shareable = 1'b1;                                                 // RULE9
          end
        end
        mpu_perm_pkg::TYPE_NC: begin
          if (a.c == a.b) begin
            m.mtype        = mpu_perm_pkg::MT_NORMAL;                           // RULE8
            m.shareable    = a.s;
            m.inner_policy = a.c ? mpu_perm_pkg::CP_WB_ALLOC : mpu_perm_pkg::CP_NONCACHE;
            m.outer_policy = m.inner_policy;
          end
        end
        mpu_perm_pkg::TYPE_NSDEV: begin
          if (!a.c && !a.b) begin
            m.mtype = mpu_perm_pkg::MT_NSDEV;                                   // RULE8
          end
        end
        default: m.mtype = mpu_perm_pkg::MT_RSVD;                               // RULE9
      endcase
    end
    return m;
  endfunction : decode

  // Per-region verdict, computed for every region in parallel
  logic [NREG-1:0] reg_ok;
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign reg_ok[gi] = perm_ok(region_attr_i[gi].access_perm_field, access_i.priv,
                                  access_i.write)
                          & ~(access_i.fetch & region_attr_i[gi].execute_never); // RULE18
    end
  endgenerate

  // Highest-numbered hit wins; later loop passes override earlier ones
  logic                       any_hit;
  logic                       sel_ok;
  mpu_perm_pkg::region_attr_t sel_attr;
  always_comb begin
    any_hit  = 1'b0;
    sel_ok   = 1'b0;
    sel_attr = '0;
    for (int i = 0; i < NREG; i++) begin
      if (region_hit_i[i]) begin
        any_hit  = 1'b1;                   // RULE16
        sel_ok   = reg_ok[i];
        sel_attr = region_attr_i[i];
      end
    end
  end

  // Verdict: disabled unit passes all, background is privileged only
  logic                    allow;
  mpu_perm_pkg::mem_attr_t eff_attr;
  always_comb begin
    allow    = 1'b1;
    eff_attr = bg_attr_i;
    if (mpu_en_i) begin
      if (any_hit) begin
        allow    = sel_ok;                 // RULE1
        eff_attr = decode(sel_attr);       // RULE12
      end else begin
        allow = access_i.priv & bg_en_i;   // RULE17
      end
    end
  end

  // Next state; status set beats a same-cycle clear
  always_comb begin
    logic viol;
    viol               = access_i.valid & ~allow;
    st_nxt             = st_r;
    st_nxt.rsp_valid   = access_i.valid;
    st_nxt.fault       = viol;
    st_nxt.mm_fault    = viol;             // RULE14
    if (access_i.valid) begin
      st_nxt.attr = eff_attr;
    end
    st_nxt.fstat = st_r.fstat & ~fstat_clr_i;
    if (viol) begin
      // Set on top of the cleared value, so a clear of the other cause still lands
      st_nxt.fstat[mpu_perm_pkg::FSTAT_IACC] = st_nxt.fstat[mpu_perm_pkg::FSTAT_IACC]
                                               | access_i.fetch;   // RULE15
      st_nxt.fstat[mpu_perm_pkg::FSTAT_DACC] = st_nxt.fstat[mpu_perm_pkg::FSTAT_DACC]
                                               | ~access_i.fetch;  // RULE15
      if (!access_i.fetch) begin
        st_nxt.faddr = access_i.addr;      // Fetch faults leave the address stale
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r       <= '0;
      st_r.fstat <= mpu_perm_pkg::FSTAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign rsp_valid_o            = st_r.rsp_valid;
  assign fault_o                = st_r.fault;
  assign mm_fault_o             = st_r.mm_fault;
  assign attr_o                 = st_r.attr;
  assign mem_fault_status_reg_o = st_r.fstat;
  assign fault_addr_o           = st_r.faddr;

  // Checks on a single hit in region 0, the simplest observable case, plus top-region, background, status and disable checks
  logic only_r0;
  assign only_r0 = access_i.valid & mpu_en_i & (region_hit_i == NREG'(1));

  AST_PERM_NONE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE3
    only_r0 && region_attr_i[0].access_perm_field == mpu_perm_pkg::PERM_NONE |=> fault_o)
    else $error("no-access region did not fault");

  AST_PERM_PRIV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE4
    only_r0 && !access_i.fetch && region_attr_i[0].access_perm_field == mpu_perm_pkg::PERM_PRIV
    |=> fault_o == !$past(access_i.priv))
    else $error("privileged-only region verdict wrong");

  AST_PERM_URO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE5
    only_r0 && !access_i.fetch && region_attr_i[0].access_perm_field == mpu_perm_pkg::PERM_URO
    |=> fault_o == ($past(access_i.write) && !$past(access_i.priv)))
    else $error("unprivileged read-only verdict wrong");

  AST_PERM_PRIV_RO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE6
    only_r0 && !access_i.fetch
    && region_attr_i[0].access_perm_field == mpu_perm_pkg::PERM_PRIV_RO
    |=> fault_o == ($past(access_i.write) || !$past(access_i.priv)))
    else $error("privileged read-only verdict wrong");

  AST_PERM_RO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE7
    only_r0 && !access_i.fetch && region_attr_i[0].access_perm_field[2:1] == 2'h3
    |=> fault_o == $past(access_i.write))
    else $error("read-only region verdict wrong");

  AST_XN: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE18
    only_r0 && access_i.fetch && region_attr_i[0].execute_never |=> fault_o)
    else $error("fetch from execute-never region passed");

  AST_HIGHEST: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE16
    access_i.valid && mpu_en_i && region_hit_i[NREG-1] && !access_i.fetch
    && region_attr_i[NREG-1].access_perm_field == mpu_perm_pkg::PERM_FULL |=> !fault_o)
    else $error("top region did not take precedence");

  AST_BG_UNPRIV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE17
    access_i.valid && mpu_en_i && region_hit_i == '0 && !access_i.priv |=> fault_o)
    else $error("unprivileged background access passed");

  AST_CACHED: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE10
    only_r0 && region_attr_i[0].type_extension_field[mpu_perm_pkg::TYPE_CACHED_BIT]
    |=> attr_o.mtype == mpu_perm_pkg::MT_NORMAL
        && attr_o.outer_policy == $past(region_attr_i[0].type_extension_field[1:0]))
    else $error("cached type decode wrong");

  AST_ORDERED: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE8
    only_r0 && region_attr_i[0].type_extension_field == mpu_perm_pkg::TYPE_BASIC
    && !region_attr_i[0].c && !region_attr_i[0].b
    |=> attr_o.mtype == mpu_perm_pkg::MT_ORDERED && attr_o.shareable)
    else $error("strongly ordered decode wrong");

  AST_STATUS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE15
    fault_o && !$past(access_i.fetch) |-> mem_fault_status_reg_o[mpu_perm_pkg::FSTAT_DACC] ##1
    (mem_fault_status_reg_o[mpu_perm_pkg::FSTAT_DACC]
     || $past(fstat_clr_i[mpu_perm_pkg::FSTAT_DACC])))
    else $error("data violation cause not recorded");

  AST_MMF: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE14
    access_i.valid && !mpu_en_i |=> !mm_fault_o && rsp_valid_o)
    else $error("fault raised with unit disabled");

  // Response pulse, fault address, status clear and device, nonshared device, write-back allocate and cached inner decode paths
  AST_RSP: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE1
    access_i.valid |=> rsp_valid_o)
    else $error("access got no response");

  AST_IDLE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE14
    !access_i.valid |=> !rsp_valid_o && !mm_fault_o)
    else $error("response without an access");

  AST_PERM_FULL: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE5
    only_r0 && !access_i.fetch && region_attr_i[0].access_perm_field == mpu_perm_pkg::PERM_FULL
    |=> !fault_o)
    else $error("full-access region faulted");

  AST_BG_PRIV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE17
    access_i.valid && mpu_en_i && region_hit_i == '0 && access_i.priv
    |=> fault_o == !$past(bg_en_i))
    else $error("privileged background verdict wrong");

  AST_OFF_ATTR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE12
    access_i.valid && !mpu_en_i |=> attr_o == $past(bg_attr_i))
    else $error("disabled unit reported wrong attributes");

  AST_FADDR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE15
    access_i.valid && !access_i.fetch ##1 fault_o |-> fault_addr_o == $past(access_i.addr))
    else $error("data fault address not captured");

  AST_FETCH_ADDR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE15
    access_i.valid && access_i.fetch ##1 fault_o |-> $stable(fault_addr_o))
    else $error("fetch fault moved the fault address");

  AST_FETCH_STATUS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE18
    access_i.valid && access_i.fetch ##1 fault_o
    |-> mem_fault_status_reg_o[mpu_perm_pkg::FSTAT_IACC])
    else $error("fetch violation cause not recorded");

  AST_CLR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE15
    fstat_clr_i[mpu_perm_pkg::FSTAT_DACC] && !(access_i.valid && !access_i.fetch)
    |=> !mem_fault_status_reg_o[mpu_perm_pkg::FSTAT_DACC])
    else $error("data status bit not cleared");

  AST_DEVICE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE8
    only_r0 && region_attr_i[0].type_extension_field == mpu_perm_pkg::TYPE_BASIC
    && !region_attr_i[0].c && region_attr_i[0].b
    |=> attr_o.mtype == mpu_perm_pkg::MT_DEVICE && attr_o.shareable)
    else $error("device decode wrong");

  AST_NSDEV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE9
    only_r0 && region_attr_i[0].type_extension_field == mpu_perm_pkg::TYPE_NSDEV
    && !region_attr_i[0].c && !region_attr_i[0].b
    |=> attr_o.mtype == mpu_perm_pkg::MT_NSDEV && !attr_o.shareable)
    else $error("nonshared device decode wrong");

  AST_TYPE_NC: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE11
    only_r0 && region_attr_i[0].type_extension_field == mpu_perm_pkg::TYPE_NC
    && region_attr_i[0].c && region_attr_i[0].b
    |=> attr_o.mtype == mpu_perm_pkg::MT_NORMAL
        && attr_o.inner_policy == mpu_perm_pkg::CP_WB_ALLOC
        && attr_o.outer_policy == mpu_perm_pkg::CP_WB_ALLOC)
    else $error("write-back allocate decode wrong");

  AST_CACHED_INNER: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE10
    only_r0 && region_attr_i[0].type_extension_field[mpu_perm_pkg::TYPE_CACHED_BIT]
    |=> attr_o.inner_policy == $past({region_attr_i[0].c, region_attr_i[0].b}))
    else $error("cached inner policy wrong");

endmodule : mpu_access_permission_check
`default_nettype wire

//--- rtl/mpu_perm_pkg.sv
// Types and constants for the protection unit permission checker
// Functional notes
// [RULE1] Check each access against the matching region permissions; fault on missing rights.
// [RULE2] Three-bit permission field, rights per privilege level; code 100 reserved.
// [RULE3] Permission 000 denies every access at both levels.
// [RULE4] Permission 001 gives privileged read-write, faults any unprivileged access.
// [RULE5] 010 gives unprivileged read-only; 011 gives full access at both levels.
// [RULE6] Permission 101 allows privileged reads only.
// [RULE7] Permissions 110 and 111 allow reads at both levels, fault writes.
// [RULE8] Type-extension 000, 001, 010 decode to ordered, device, nonshared device, normal or reserved.
// [RULE9] Shareable bit ignored for ordered, device, nonshared device, reserved types.
// [RULE10] Type-extension top bit set gives normal cached memory, outer and inner.
// [RULE11] Policy codes: non-cacheable, write-back allocate, write-through, write-back.
// [RULE12] Cache and share attributes are reported only, never change checking.
// [RULE13] Software should use type-extension 000 with the typical region settings.
// [RULE14] A violating access raises a memory management fault to the core.
// [RULE15] The fault cause is recorded in the memory fault status register.
// [RULE16] Overlapping enabled regions: the highest-numbered region wins.
// [RULE17] Background region is privileged only; unmatched unprivileged access faults.
// [RULE18] Execute-never region blocks instruction fetches with a fault.
package mpu_perm_pkg;

  localparam int unsigned NUM_REGIONS = 8;
  localparam int unsigned ADDR_W      = 32;

  // Permission field codes
  localparam logic [2:0] PERM_NONE    = 3'h0;
  localparam logic [2:0] PERM_PRIV    = 3'h1;
  localparam logic [2:0] PERM_URO     = 3'h2;
  localparam logic [2:0] PERM_FULL    = 3'h3;
  localparam logic [2:0] PERM_RSVD    = 3'h4;
  localparam logic [2:0] PERM_PRIV_RO = 3'h5;
  localparam logic [2:0] PERM_RO_A    = 3'h6;
  localparam logic [2:0] PERM_RO_B    = 3'h7;

  // Type-extension codes
  localparam logic [2:0]  TYPE_BASIC      = 3'h0;
  localparam logic [2:0]  TYPE_NC         = 3'h1;
  localparam logic [2:0]  TYPE_NSDEV      = 3'h2;
  localparam int unsigned TYPE_CACHED_BIT = 2;

  // Status register bit positions and width
  localparam int unsigned FSTAT_W   = 2;
  localparam int unsigned FSTAT_IACC = 0;
  localparam int unsigned FSTAT_DACC = 1;
  localparam logic [1:0] FSTAT_RST   = 2'h0;

  typedef enum logic [2:0] {
    MT_ORDERED = 3'b000,
    MT_DEVICE  = 3'b001,
    MT_NSDEV   = 3'b010,
    MT_NORMAL  = 3'b011,
    MT_RSVD    = 3'b100
  } mem_type_t;

  typedef enum logic [1:0] {
    CP_NONCACHE = 2'b00,
    CP_WB_ALLOC = 2'b01,
    CP_WT_NOWA  = 2'b10,
    CP_WB_NOWA  = 2'b11
  } cache_pol_t;

  // Attribute bits of one region
  typedef struct packed {
    logic       execute_never;
    logic [2:0] access_perm_field;
    logic [2:0] type_extension_field;
    logic       s;
    logic       c;
    logic       b;
  } region_attr_t;

  // One access from the core
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              fetch;
    logic              priv;
    logic [ADDR_W-1:0] addr;
  } access_t;

  // Decoded attributes
  typedef struct packed {
    mem_type_t  mtype;
    logic       shareable;
    cache_pol_t inner_policy;
    cache_pol_t outer_policy;
  } mem_attr_t;

endpackage : mpu_perm_pkg

//--- verif/core_model.sv
// Behavioural processor core that issues single checked accesses
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // Clock
  input  wire logic                                      clk_i,
  // Access request toward the checker
  output var  mpu_perm_pkg::access_t                     access_o,
  output var  logic [mpu_perm_pkg::NUM_REGIONS-1:0]      region_hit_o
);
  // Idle values at time zero
  initial begin
    access_o     = '0;
    region_hit_o = '0;
  end

  // One-cycle strobe; released lines show inverted values so stale data never looks valid
  task automatic issue(input logic wr, input logic fe, input logic pv,
                       input logic [31:0] ad, input logic [7:0] hit);
    @(posedge clk_i);
    access_o     <= '{valid: 1'b1, write: wr, fetch: fe, priv: pv, addr: ad};
    region_hit_o <= hit;
    @(posedge clk_i);
    access_o     <= '{valid: 1'b0, write: ~wr, fetch: ~fe, priv: ~pv, addr: ~ad};
    region_hit_o <= ~hit;
    #1;
  endtask : issue
endmodule : core_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the region permission checker
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                                 clk;
  logic                                 rstn;
  logic                                 mpu_en;
  logic                                 bg_en;
  mpu_perm_pkg::region_attr_t [7:0]     ra;
  mpu_perm_pkg::mem_attr_t              bg_attr;
  mpu_perm_pkg::access_t                acc;
  logic [7:0]                           hit;
  logic [1:0]                           clr;
  logic                                 rsp_v;
  logic                                 flt;
  logic                                 mmf;
  mpu_perm_pkg::mem_attr_t              attr;
  logic [1:0]                           stat;
  logic [31:0]                          faddr;
  int                                   num_errors;
  int                                   n_checks;
  logic                                 ef;

  core_model u_core (.clk_i(clk), .access_o(acc), .region_hit_o(hit));

  mpu_access_permission_check #(.NREG(8)) uut (
    .ref_clk_i(clk), .rstn_i(rstn), .mpu_en_i(mpu_en), .bg_en_i(bg_en),
    .region_attr_i(ra), .bg_attr_i(bg_attr), .access_i(acc), .region_hit_i(hit),
    .fstat_clr_i(clr), .rsp_valid_o(rsp_v), .fault_o(flt), .mm_fault_o(mmf),
    .attr_o(attr), .mem_fault_status_reg_o(stat), .fault_addr_o(faddr));

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Reserved code 100 grants nothing, as chosen for this block
  function automatic logic perm_ok(input logic [2:0] perm, input logic pv, input logic wr);
    case (perm)
      3'h1:    return pv;
      3'h2:    return pv | ~wr;
      3'h3:    return 1'b1;
      3'h5:    return pv & ~wr;
      3'h6,
      3'h7:    return ~wr;
      default: return 1'b0;
    endcase
  endfunction : perm_ok

  function automatic mpu_perm_pkg::mem_attr_t exp_attr(input logic [2:0] t, input logic s,
                                                       input logic c, input logic b);
    mpu_perm_pkg::mem_attr_t e;
    e = '0;
    e.shareable = s;
    if (t[2]) begin
      e.mtype        = mpu_perm_pkg::MT_NORMAL;
      e.inner_policy = mpu_perm_pkg::cache_pol_t'({c, b});
      e.outer_policy = mpu_perm_pkg::cache_pol_t'(t[1:0]);
    end else if (t == 3'h0 && !c) begin
      e.mtype     = b ? mpu_perm_pkg::MT_DEVICE : mpu_perm_pkg::MT_ORDERED;
      e.shareable = 1'b1;
    end else if (t == 3'h0) begin
      e.mtype        = mpu_perm_pkg::MT_NORMAL;
      e.inner_policy = b ? mpu_perm_pkg::CP_WB_NOWA : mpu_perm_pkg::CP_WT_NOWA;
      e.outer_policy = e.inner_policy;
    end else if (t == 3'h1 && c == b) begin
      e.mtype        = mpu_perm_pkg::MT_NORMAL;
      e.inner_policy = c ? mpu_perm_pkg::CP_WB_ALLOC : mpu_perm_pkg::CP_NONCACHE;
      e.outer_policy = e.inner_policy;
    end else begin
      e.mtype     = (t == 3'h2 && !c && !b) ? mpu_perm_pkg::MT_NSDEV : mpu_perm_pkg::MT_RSVD;
      e.shareable = 1'b0;
    end
    return e;
  endfunction : exp_attr

  // Sets one region's permission and execute-never bits, normal memory type
  task automatic set_perm(input int r, input logic no_exec, input logic [2:0] perm);
    @(posedge clk);
    ra[r] <= '{execute_never: no_exec, access_perm_field: perm, type_extension_field: 3'h0,
               s: 1'b0, c: 1'b1, b: 1'b0};
  endtask : set_perm

  // Access then compare the verdict pulses
  task automatic acc_chk(input logic wr, input logic fe, input logic pv, input logic [31:0] ad,
                         input logic [7:0] h, input logic exp_f);
    u_core.issue(wr, fe, pv, ad, h);
    check(32'(rsp_v), 32'h1);
    check(32'(flt), 32'(exp_f));
    check(32'(mmf), 32'(exp_f));
  endtask : acc_chk

  task automatic clear_stat(input logic [1:0] m);
    @(posedge clk);
    clr <= m;
    @(posedge clk);
    clr <= 2'h0;
    #1;
  endtask : clear_stat

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    clk        = 1'b0;
    rstn       = 1'b0;
    mpu_en     = 1'b1;
    bg_en      = 1'b0;
    ra         = '0;
    clr        = 2'h0;
    num_errors = 0;
    n_checks   = 0;
    bg_attr = '{mtype: mpu_perm_pkg::MT_DEVICE, shareable: 1'b1,
                inner_policy: mpu_perm_pkg::CP_WT_NOWA, outer_policy: mpu_perm_pkg::CP_WB_ALLOC};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // Every permission code against every privilege and direction
    for (int pc = 0; pc < 8; pc++) begin
      set_perm(0, 1'b0, 3'(pc));
      for (int k = 0; k < 4; k++) begin
        ef = ~perm_ok(3'(pc), k[1], k[0]);
        acc_chk(k[0], 1'b0, k[1], 32'h0000_1000 + 32'(k), 8'h01, ef);
      end
    end
    $display("test permissions done");
    // All type-extension, shareable, cacheable, bufferable combinations, full access
    for (int n = 0; n < 64; n++) begin
      @(posedge clk);
      ra[0] <= '{execute_never: 1'b0, access_perm_field: 3'h3, type_extension_field: 3'(n >> 3),
                 s: n[2], c: n[1], b: n[0]};
      u_core.issue(n[3], 1'b0, n[4], 32'h2000_0000, 8'h01);
      check(32'(attr), 32'(exp_attr(3'(n >> 3), n[2], n[1], n[0])));
      check(32'(flt), 32'h0);
    end
    $display("test attributes done");
    // Overlap: highest region decides
    set_perm(2, 1'b0, 3'h0);
    set_perm(5, 1'b0, 3'h3);
    acc_chk(1'b1, 1'b0, 1'b0, 32'h0000_4000, 8'h24, 1'b0);
    set_perm(2, 1'b0, 3'h3);
    set_perm(5, 1'b0, 3'h0);
    acc_chk(1'b1, 1'b0, 1'b1, 32'h0000_4004, 8'h24, 1'b1);
    // Top region over a no-access region below it
    set_perm(7, 1'b0, 3'h3);
    acc_chk(1'b1, 1'b0, 1'b0, 32'h0000_4008, 8'ha0, 1'b0);
    $display("test overlap done");
    // Background region
    @(posedge clk);
    bg_en <= 1'b1;
    acc_chk(1'b1, 1'b0, 1'b1, 32'h0000_5000, 8'h00, 1'b0);
    check(32'(attr), 32'(bg_attr));
    acc_chk(1'b0, 1'b0, 1'b0, 32'h0000_5004, 8'h00, 1'b1);
    @(posedge clk);
    bg_en <= 1'b0;
    acc_chk(1'b0, 1'b0, 1'b1, 32'h0000_5008, 8'h00, 1'b1);
    $display("test background done");
    // Fault status, fault address and execute-never
    clear_stat(2'h3);
    check(32'(stat), 32'h0);
    set_perm(0, 1'b0, 3'h0);
    set_perm(1, 1'b1, 3'h3);
    acc_chk(1'b0, 1'b0, 1'b1, 32'h2000_0040, 8'h01, 1'b1);
    check(32'(stat), 32'h2);
    check(faddr, 32'h2000_0040);
    acc_chk(1'b0, 1'b1, 1'b1, 32'h0000_3000, 8'h02, 1'b1);
    check(32'(stat), 32'h3);
    check(faddr, 32'h2000_0040);
    acc_chk(1'b0, 1'b0, 1'b0, 32'h0000_3004, 8'h02, 1'b0);
    clear_stat(2'h2);
    check(32'(stat), 32'h1);
    clear_stat(2'h1);
    check(32'(stat), 32'h0);
    $display("test status done");
    // Unit disabled: no checks, background attributes reported
    @(posedge clk);
    mpu_en <= 1'b0;
    acc_chk(1'b1, 1'b1, 1'b0, 32'h0000_6000, 8'h01, 1'b0);
    check(32'(attr), 32'(bg_attr));
    $display("test disable done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
